// File: hw/fbcs_consts.svh
// Constants of the fast battery charge sequencer
// How it works
// - Fast charge ends after 655,360 mains pulses, then trickle follows.
// - A start delay of 7680 mains pulses follows battery insertion; a timer reset skips it.
// - Delay and charge counters both advance only on rectified mains pulses.
// - Fast charge never starts above the high or below the low limit.
// - Absolute temperature flag during fast charge ends the cycle at once.
// - Over-ambient flag during fast charge ends the cycle.
// - Rate input high gives 7/8 fast duty, low gives 7/16.
// - Rate changes only alter duty, never the charge time counting.
// - Outside fast charge, with a battery present, trickle at 1/16 (full rate) or 1/32 (half rate).
// - Hold variant: override high forces trickle regardless of fast state.
// - Hold variant: charge timer keeps counting while trickle is forced.
// - Hold variant: override low resumes fast charge unless timer expired.
// - Reset variant: override falling edge clears timer, starts new cycle.
// - Zero crossings on battery sense mean no battery; charging waits.
// - Each conducting half-cycle carries a 1.5 kHz gate pulse train.
// - Indicator steady with no battery, in delay and trickle; 3 Hz in fast.
`ifndef FBCS_CONSTS_SVH
`define FBCS_CONSTS_SVH

`define FBCS_CHARGE_LIMIT  20'hA0000
`define FBCS_DELAY_LIMIT   13'h1E00
`define FBCS_QUIET_PULSES  3'h4

`define FBCS_CLK_HZ        250000000
`define FBCS_GATE_HZ       1500
`define FBCS_IND_HZ        3
`define FBCS_GATE_HALF_CYC (`FBCS_CLK_HZ / (2 * `FBCS_GATE_HZ))
`define FBCS_IND_HALF_CYC  (`FBCS_CLK_HZ / (2 * `FBCS_IND_HZ))

`define FBCS_FAST_FULL_SKIP 3'h7
`define FBCS_FAST_HALF_ON   4'h7
`define FBCS_TRKL_FULL_SLOT 4'h0
`define FBCS_TRKL_HALF_SLOT 5'h00

`endif

// File: hw/fbcs_pkg.sv
// Types shared by the charge sequencer modules
package fbcs_pkg;

    typedef enum logic [2:0] {
        FBCS_NO_BATT,
        FBCS_DELAY,
        FBCS_WAIT_TEMP,
        FBCS_FAST,
        FBCS_TRICKLE
    } fbcs_state_t;

    typedef enum logic [1:0] {
        FBCS_DUTY_FAST_FULL,
        FBCS_DUTY_FAST_HALF,
        FBCS_DUTY_TRKL_FULL,
        FBCS_DUTY_TRKL_HALF
    } fbcs_duty_t;

endpackage : fbcs_pkg

// File: hw/fbcs_wave_if.sv
// Run request and square wave between sequencer and wave generator
`timescale 1ns/1ps
interface fbcs_wave_if;
    logic run;
    logic wave;

    modport gen  (input run, output wave);
    modport sink (output run, input wave);
endinterface : fbcs_wave_if

// File: hw/fbcs_toggler.sv
// Square wave generator that runs while requested
`timescale 1ns/1ps
module fbcs_toggler #(
    parameter int unsigned HALF = 2
) (
    input  wire logic  clk_i,
    input  wire logic  nrst_i,
    fbcs_wave_if.gen   w
);
    import fbcs_pkg::*;

    localparam int unsigned W = $clog2(HALF + 1);
    localparam logic [W-1:0] LAST = W'(HALF - 1);

    logic [W-1:0] cnt;

    // Idle low, so a stopped wave never leaves a pulse hanging
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt    <= '0;
            w.wave <= 1'b0;
        end else if (!w.run) begin
            cnt    <= '0;
            w.wave <= 1'b0;
        end else if (cnt == LAST) begin
            cnt    <= '0;
            w.wave <= ~w.wave;
        end else begin
            cnt    <= cnt + 1'b1;
        end
    end

endmodule : fbcs_toggler

// File: hw/fbcs_top.sv
// Fast battery charge sequencer: timing, duty selection and gate drive
`timescale 1ns/1ps
`include "fbcs_consts.svh"
module fbcs_top #(
    parameter int unsigned GATE_HALF = `FBCS_GATE_HALF_CYC,
    parameter int unsigned IND_HALF  = `FBCS_IND_HALF_CYC
) (
    input  wire logic          clk_i,
    input  wire logic          nrst_i,
    input  wire logic          mains_pulse_i,
    input  wire logic          batt_sense_i,
    input  wire logic          rate_full_i,
    input  wire logic          override_i,
    input  wire logic          hold_variant_i,
    input  wire logic          absolute_temp_limit_flag_i,
    input  wire logic          upper_start_limit_flag_i,
    input  wire logic          lower_start_limit_flag_i,
    input  wire logic          over_ambient_limit_flag_i,
    output logic               thyristor_gate_pulse_o,
    output logic               indicator_output_o,
    output logic               fast_charge_o,
    output logic               battery_present_o,
    output logic               timer_expired_o,
    output fbcs_pkg::fbcs_state_t state_o
);
    import fbcs_pkg::*;

    fbcs_state_t  state;
    fbcs_state_t  next_state;
    fbcs_duty_t   duty;

    logic         mains_q;
    logic         mains_edge;
    logic         override_q;
    logic         override_fall;
    logic         zc_pend;
    logic [2:0]   quiet_cnt;
    logic         present;
    logic [12:0]  delay_cnt;
    logic [19:0]  charge_cnt;
    logic         delay_done;
    logic         charge_done;
    logic         forced_trickle;
    logic         fast_eff;
    logic         timer_reset;
    logic [4:0]   frame;
    logic         fire_now;
    logic         fire_half;
    logic         expired;

    fbcs_wave_if  gate_w ();
    fbcs_wave_if  ind_w ();

    // Edge detection on the synchronous pins
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mains_q    <= 1'b0;
            override_q <= 1'b0;
        end else begin
            mains_q    <= mains_pulse_i;
            override_q <= override_i;
        end
    end

    // Edge registers reset low, the resting level of both pins,
    // so no false edge follows reset
    assign mains_edge    = mains_pulse_i & ~mains_q;
    assign override_fall = override_q & ~override_i;
    assign timer_reset   = override_fall & ~hold_variant_i;

    // A low sense level anywhere in a half-cycle counts as a zero crossing.
    // The new sample wins over the clear at the mains edge.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            zc_pend <= 1'b0;
        end else if (mains_edge) begin
            zc_pend <= ~batt_sense_i;
        end else if (!batt_sense_i) begin
            zc_pend <= 1'b1;
        end
    end

    // Presence needs several quiet half-cycles, to ride out noise
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            quiet_cnt <= 3'h0;
        end else if (!batt_sense_i) begin
            quiet_cnt <= 3'h0;
        end else if (mains_edge) begin
            if (zc_pend) begin
                quiet_cnt <= 3'h0;
            end else if (quiet_cnt != `FBCS_QUIET_PULSES) begin
                quiet_cnt <= quiet_cnt + 3'h1;
            end
        end
    end

    assign present = (quiet_cnt == `FBCS_QUIET_PULSES);

    // Start delay counter, live only in the delay state
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            delay_cnt <= 13'h0000;
        end else if (state != FBCS_DELAY) begin
            delay_cnt <= 13'h0000;
        end else if (mains_edge) begin
            delay_cnt <= delay_cnt + 13'h0001;
        end
    end

    assign delay_done = mains_edge
                        && (delay_cnt == `FBCS_DELAY_LIMIT - 13'h0001);

    // Charge timer ignores the rate input and the override level
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            charge_cnt <= 20'h00000;
        end else if (state != FBCS_FAST) begin
            charge_cnt <= 20'h00000;
        end else if (mains_edge) begin
            charge_cnt <= charge_cnt + 20'h00001;
        end
    end

    assign charge_done = mains_edge
                         && (charge_cnt == `FBCS_CHARGE_LIMIT - 20'h00001);

    assign forced_trickle = hold_variant_i & override_i;
    assign fast_eff       = (state == FBCS_FAST) && !forced_trickle;

    // Sequencing; removal and timer reset override everything else.
    // A timer reset skips the start delay but still waits for the limits.
    always_comb begin
        next_state = state;
        case (state)
            FBCS_NO_BATT: begin
                if (present) begin
                    next_state = FBCS_DELAY;
                end
            end
            FBCS_DELAY: begin
                if (delay_done) begin
                    next_state = FBCS_WAIT_TEMP;
                end
            end
            FBCS_WAIT_TEMP: begin
                if (!upper_start_limit_flag_i
                    && !lower_start_limit_flag_i) begin
                    next_state = FBCS_FAST;
                end
            end
            FBCS_FAST: begin
                if (absolute_temp_limit_flag_i) begin
                    next_state = FBCS_TRICKLE;
                end else if (over_ambient_limit_flag_i) begin
                    next_state = FBCS_TRICKLE;
                end else if (charge_done) begin
                    next_state = FBCS_TRICKLE;
                end
            end
            FBCS_TRICKLE: begin
                next_state = FBCS_TRICKLE;
            end
            default: begin
                next_state = FBCS_NO_BATT;
            end
        endcase
        if (timer_reset) begin
            next_state = FBCS_WAIT_TEMP;
        end
        if (!present) begin
            next_state = FBCS_NO_BATT;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= FBCS_NO_BATT;
        end else begin
            state <= next_state;
        end
    end

    // Expiry stays visible until a new cycle or a removal
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            expired <= 1'b0;
        end else if (state == FBCS_FAST && charge_done) begin
            expired <= 1'b1;
        end else if (timer_reset || next_state == FBCS_NO_BATT) begin
            expired <= 1'b0;
        end
    end

    // Duty choice; rate is read live so a change takes the next half-cycle
    always_comb begin
        if (fast_eff) begin
            duty = rate_full_i ? FBCS_DUTY_FAST_FULL
                               : FBCS_DUTY_FAST_HALF;
        end else begin
            duty = rate_full_i ? FBCS_DUTY_TRKL_FULL
                               : FBCS_DUTY_TRKL_HALF;
        end
    end

    always_comb begin
        case (duty)
            FBCS_DUTY_FAST_FULL: begin
                fire_now = (frame[2:0] != `FBCS_FAST_FULL_SKIP);
            end
            FBCS_DUTY_FAST_HALF: begin
                fire_now = (frame[3:0] < `FBCS_FAST_HALF_ON);
            end
            FBCS_DUTY_TRKL_FULL: begin
                fire_now = (frame[3:0] == `FBCS_TRKL_FULL_SLOT);
            end
            FBCS_DUTY_TRKL_HALF: begin
                fire_now = (frame == `FBCS_TRKL_HALF_SLOT);
            end
            default: begin
                fire_now = 1'b0;
            end
        endcase
    end

    // Frame of 32 half-cycles covers every duty pattern
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            frame <= 5'h00;
        end else if (mains_edge) begin
            frame <= frame + 5'h01;
        end
    end

    // Firing decision is held for the whole half-cycle
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fire_half <= 1'b0;
        end else if (!present) begin
            fire_half <= 1'b0;
        end else if (mains_edge) begin
            fire_half <= fire_now;
        end
    end

    assign gate_w.run = fire_half;
    assign ind_w.run  = fast_eff;

    fbcs_toggler #(
        .HALF (GATE_HALF)
    ) u_gate (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .w      (gate_w.gen)
    );

    fbcs_toggler #(
        .HALF (IND_HALF)
    ) u_ind (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .w      (ind_w.gen)
    );

    // All outputs registered
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            thyristor_gate_pulse_o <= 1'b0;
            indicator_output_o     <= 1'b1;
        end else begin
            thyristor_gate_pulse_o <= gate_w.wave;
            indicator_output_o     <= fast_eff ? ind_w.wave
                                               : 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fast_charge_o     <= 1'b0;
            battery_present_o <= 1'b0;
            timer_expired_o   <= 1'b0;
            state_o           <= FBCS_NO_BATT;
        end else begin
            fast_charge_o     <= fast_eff;
            battery_present_o <= present;
            timer_expired_o   <= expired;
            state_o           <= state;
        end
    end

endmodule : fbcs_top

// File: dv/fbcs_properties.sv
// Port-level temporal checks for the charge sequencer
`timescale 1ns/1ps
module fbcs_top_props (
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        batt_sense_i,
    input wire logic        rate_full_i,
    input wire logic        override_i,
    input wire logic        hold_variant_i,
    input wire logic        absolute_temp_limit_flag_i,
    input wire logic        upper_start_limit_flag_i,
    input wire logic        lower_start_limit_flag_i,
    input wire logic        over_ambient_limit_flag_i,
    input wire logic        indicator_output_o,
    input wire logic        fast_charge_o,
    input wire logic        battery_present_o,
    input wire fbcs_pkg::fbcs_state_t state_o
);
    import fbcs_pkg::*;

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    abs_stop_a: assert property (
        state_o == FBCS_FAST && absolute_temp_limit_flag_i
        |-> ##[1:3] state_o inside {FBCS_TRICKLE, FBCS_NO_BATT})
        else $error("fast charge kept past max temperature");
    ambient_stop_a: assert property (
        state_o == FBCS_FAST && over_ambient_limit_flag_i
        |-> ##[1:3] state_o inside {FBCS_TRICKLE, FBCS_NO_BATT})
        else $error("fast charge kept past ambient delta");
    start_block_a: assert property (
        state_o == FBCS_FAST && $past(state_o) == FBCS_WAIT_TEMP
        |-> !$past(upper_start_limit_flag_i, 2)
            && !$past(lower_start_limit_flag_i, 2))
        else $error("fast charge started out of temperature window");
    ind_steady_a: assert property (
        (state_o inside {FBCS_NO_BATT, FBCS_DELAY, FBCS_TRICKLE})[*3]
        |-> indicator_output_o)
        else $error("indicator not steady outside fast charge");
    batt_gone_a: assert property (
        !batt_sense_i
        |-> ##[1:3] (state_o == FBCS_NO_BATT && !battery_present_o))
        else $error("zero crossing did not mark battery absent");
    no_batt_idle_a: assert property (
        !battery_present_o [*2] |-> !fast_charge_o)
        else $error("fast charge without battery");
    rate_keep_a: assert property (
        fast_charge_o && $changed(rate_full_i) && batt_sense_i
        && !override_i && !absolute_temp_limit_flag_i
        && !over_ambient_limit_flag_i |=> fast_charge_o)
        else $error("rate change disturbed fast charge");
    hold_force_a: assert property (
        (hold_variant_i && override_i)[*3] |-> !fast_charge_o)
        else $error("hold override did not force trickle");
endmodule : fbcs_top_props

// File: dv/fbcs_mains_model.sv
// Rectified mains and battery sense model for the sequencer bench
`timescale 1ns/1ps
module fbcs_mains_model (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       batt_in_i,
    input  wire logic [7:0] period_i,
    output logic            mains_pulse_o,
    output logic            batt_sense_o
);
    logic [7:0] phase;

    // One clock wide pulse per half-cycle, low in between
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase <= 8'h00;
            mains_pulse_o <= 1'b0;
        end else begin
            phase <= (phase + 8'h01 >= period_i) ? 8'h00 : phase + 8'h01;
            mains_pulse_o <= (phase == 8'h00);
        end
    end

    // Empty holder lets every half-cycle cross zero
    assign batt_sense_o = batt_in_i | ~mains_pulse_o;
endmodule : fbcs_mains_model

// File: dv/test_fast_battery_charge_sequencer.sv
// Self-checking bench for the charge sequencer
`timescale 1ns/1ps
module test_fast_battery_charge_sequencer;
    import fbcs_pkg::*;
    localparam int unsigned GH = 4;
    localparam int unsigned IH = 10;
    logic        clk_i, nrst_i, mains, sense, rate, ovr, hold, seen;
    logic        t_abs, t_up, t_lo, t_amb, batt, gate, ind, fast, pres, expd;
    logic [7:0]  period;
    logic [3:0]  ph;
    logic [31:0] rnd;
    fbcs_state_t st;
    int          num_errors, check_count, fired, cyc, n;

    fbcs_mains_model pm (.clk_i(clk_i), .nrst_i(nrst_i), .batt_in_i(batt),
        .period_i(period), .mains_pulse_o(mains), .batt_sense_o(sense));
    fbcs_top #(.GATE_HALF(GH), .IND_HALF(IH)) dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .mains_pulse_i(mains),
        .batt_sense_i(sense), .rate_full_i(rate), .override_i(ovr),
        .hold_variant_i(hold), .absolute_temp_limit_flag_i(t_abs),
        .upper_start_limit_flag_i(t_up), .lower_start_limit_flag_i(t_lo),
        .over_ambient_limit_flag_i(t_amb), .thyristor_gate_pulse_o(gate),
        .indicator_output_o(ind), .fast_charge_o(fast),
        .battery_present_o(pres), .timer_expired_o(expd), .state_o(st));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Fired half-cycles; the lead-in skips the previous train's tail
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (mains) begin
            fired <= fired + int'(seen);
            seen <= 1'b0;
            ph <= 4'h0;
        end else begin
            if (ph != 4'hF) ph <= ph + 4'h1;
            if (ph >= 4'h4 && gate) seen <= 1'b1;
        end
        if (cyc == 50000) begin
            num_errors++;
            final_report();
        end
    end

    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction : xs

    function automatic int exp_fired(input bit fm, input logic full);
        if (fm) return full ? 28 : 14;
        return full ? 2 : 1;
    endfunction : exp_fired

    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask : tick

    task automatic cmp_bit(input string what, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %b seen %b", what, e, g);
        end
    endtask : cmp_bit

    task automatic cmp_int(input string what, input int e, input int g);
        check_count++;
        if (g != e) begin
            num_errors++;
            $display("MISMATCH %s expected %0d seen %0d", what, e, g);
        end
    endtask : cmp_int

    task automatic wait_st(input fbcs_state_t s, input int lim);
        int k;
        k = 0;
        while (st !== s && k < lim) begin
            tick(1);
            k++;
        end
        check_count++;
        if (st !== s) begin
            num_errors++;
            $display("MISMATCH state expected %s seen %s",
                     s.name(), st.name());
        end
    endtask : wait_st

    task automatic pulses(input int k);
        repeat (k) begin
            tick(1);
            while (mains !== 1'b1) tick(1);
        end
    endtask : pulses

    // Counts 32 half-cycles, so every frame phase is covered once
    task automatic duty(input bit fm);
        int f0;
        pulses(2);
        f0 = fired;
        pulses(32);
        cmp_int("fired half-cycles", exp_fired(fm, rate), fired - f0);
    endtask : duty

    task automatic ind_chk(input logic tog);
        int t;
        logic p;
        t = 0;
        p = ind;
        repeat (4 * IH) begin
            tick(1);
            if (ind !== p) t++;
            p = ind;
        end
        cmp_bit("indicator toggling", tog, t > 0);
        if (!tog) begin
            cmp_bit("indicator level", 1'b1, ind);
        end
    endtask : ind_chk

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    initial begin
        nrst_i = 1'b0;
        seen = 1'b0;
        ph = 4'h0;
        {fired, cyc, num_errors, check_count} = '0;
        rnd = 32'hE01F89C2;
        period = 8'h02;
        // Full rate, hold variant, upper limit up, no battery yet
        {rate, ovr, hold, t_abs, t_up, t_lo, t_amb, batt} = 8'hA8;
        tick(3);
        wait_st(FBCS_NO_BATT, 0);
        cmp_bit("reset indicator", 1'b1, ind);
        cmp_bit("reset gate", 1'b0, gate);
        nrst_i = 1'b1;
        tick(20);
        wait_st(FBCS_NO_BATT, 0);
        batt = 1'b1;
        n = 0;
        while (st !== FBCS_WAIT_TEMP && cyc < 40000) begin
            tick(1);
            if (st === FBCS_DELAY && mains === 1'b1) n++;
        end
        cmp_bit("delay pulses", 1'b1, n >= 7678 && n <= 7682);
        tick(10);
        wait_st(FBCS_WAIT_TEMP, 0);
        t_up = 1'b0;
        t_lo = 1'b1;
        tick(10);
        wait_st(FBCS_WAIT_TEMP, 0);
        t_lo = 1'b0;
        wait_st(FBCS_FAST, 6);
        $display("test start sequence done");
        period = 8'h10;
        duty(1'b1);
        rate = 1'b0;
        duty(1'b1);
        ind_chk(1'b1);
        repeat (60) begin
            void'(xs());
            rate = rnd[0];
            tick(3);
        end
        rate = 1'b1;
        cmp_bit("fast after rate changes", 1'b1, fast);
        $display("test fast duty done");
        ovr = 1'b1;
        tick(5);
        cmp_bit("forced trickle", 1'b0, fast);
        wait_st(FBCS_FAST, 0);
        duty(1'b0);
        ovr = 1'b0;
        tick(5);
        cmp_bit("fast resumed", 1'b1, fast);
        t_abs = 1'b1;
        wait_st(FBCS_TRICKLE, 4);
        t_abs = 1'b0;
        cmp_bit("timer expired", 1'b0, expd);
        duty(1'b0);
        rate = 1'b0;
        duty(1'b0);
        ind_chk(1'b0);
        $display("test hold and trickle done");
        nrst_i = 1'b0;
        hold = 1'b0;
        period = 8'h02;
        rate = 1'b1;
        tick(3);
        nrst_i = 1'b1;
        wait_st(FBCS_FAST, 16000);
        t_amb = 1'b1;
        wait_st(FBCS_TRICKLE, 4);
        t_amb = 1'b0;
        ovr = 1'b1;
        tick(2);
        ovr = 1'b0;
        wait_st(FBCS_FAST, 6);
        batt = 1'b0;
        wait_st(FBCS_NO_BATT, 6);
        cmp_bit("battery present", 1'b0, pres);
        batt = 1'b1;
        wait_st(FBCS_DELAY, 20);
        $display("test reset variant done");
        final_report();
    end
endmodule : test_fast_battery_charge_sequencer

bind fbcs_top fbcs_top_props chk (.clk_i(clk_i), .nrst_i(nrst_i),
    .batt_sense_i(batt_sense_i), .rate_full_i(rate_full_i),
    .override_i(override_i), .hold_variant_i(hold_variant_i),
    .absolute_temp_limit_flag_i(absolute_temp_limit_flag_i),
    .upper_start_limit_flag_i(upper_start_limit_flag_i),
    .lower_start_limit_flag_i(lower_start_limit_flag_i),
    .over_ambient_limit_flag_i(over_ambient_limit_flag_i),
    .indicator_output_o(indicator_output_o), .fast_charge_o(fast_charge_o),
    .battery_present_o(battery_present_o), .state_o(state_o));
